// file: include/tcp_defs.svh
// Register indices, field positions, reset values and timing counts of the timer pair
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define TCP_IDX_RUN 10'h088
`define TCP_IDX_MODE 10'h089
`define TCP_IDX_CNT0 10'h08a
`define TCP_IDX_CNT1 10'h08b
`define TCP_IDX_IRQ_STAT 10'h08c
`define TCP_IDX_IRQ_CLR 10'h08d
`define TCP_IDX_IRQ_EN 10'h08e

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define TCP_GATE1_BIT 7
`define TCP_FUNC1_BIT 6
`define TCP_MODE1_HI 5
`define TCP_MODE1_LO 4
`define TCP_GATE0_BIT 3
`define TCP_FUNC0_BIT 2
`define TCP_MODE0_HI 1
`define TCP_MODE0_LO 0
`define TCP_FLAG1_BIT 7
`define TCP_RUN1_BIT 6
`define TCP_FLAG0_BIT 5
`define TCP_RUN0_BIT 4
`define TCP_MODE_RESET 8'h00
`define TCP_CNT_RESET 16'h0000

// ********************************************************************
// Timing
// ********************************************************************
`define TCP_OSC_PERIOD_NS 10
`define TCP_MC_PERIOD_NS 60
`define TCP_MC_CYCLES (`TCP_MC_PERIOD_NS / `TCP_OSC_PERIOD_NS)

// ********************************************************************
// Bus answers
// ********************************************************************
`define TCP_RESP_OKAY 2'b00
`define TCP_RESP_SLVERR 2'b10

`endif

// file: include/tcp_pkg.sv
// Types shared by the timer pair
package tcp_pkg;

  typedef enum logic [1:0] {
    TCP_M13 = 2'b00,
    TCP_M16 = 2'b01,
    TCP_RELOAD = 2'b10,
    TCP_SPLIT = 2'b11
  } tcp_opmode_t;

  typedef struct packed {
    logic gate;
    logic func_counter;
    tcp_opmode_t mode;
  } tcp_tcfg_t;

  typedef struct packed {
    tcp_tcfg_t one;
    tcp_tcfg_t zero;
  } tcp_mode_reg_t;

endpackage : tcp_pkg

// file: logic/tcp_byte_pair.sv
// One high/low count byte pair with its four operating modes
`timescale 1ns/10ps
`include "tcp_defs.svh"

module tcp_byte_pair
  import tcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire tcp_opmode_t mode,
  input wire logic step,
  input wire logic step_high,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] count,
  output logic ovf_main,
  output logic ovf_high
);

  logic [7:0] low;
  logic [7:0] high;

  assign count = {high, low};

  // ********************************************************************
  // Overflow detection
  // ********************************************************************
  always_comb begin
    ovf_main = 1'b0;
    ovf_high = step_high && (mode == TCP_SPLIT) && (high == 8'hff);
    if (step) begin
      unique case (mode)
        TCP_M13: ovf_main = (low[4:0] == 5'h1f) && (high == 8'hff);
        TCP_M16: ovf_main = ({high, low} == 16'hffff);
        TCP_RELOAD: ovf_main = (low == 8'hff);
        TCP_SPLIT: ovf_main = (low == 8'hff);
      endcase
    end
  end

  // ********************************************************************
  // Count update
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      high <= 8'h00;
      low <= 8'h00;
    end else if (load) begin
      {high, low} <= load_val;
    end else begin
      if (step) begin
        unique case (mode)
          TCP_M13: begin
            // Upper three low-byte bits are left alone; they carry no meaning here
            low[4:0] <= low[4:0] + 5'h01;
            if (low[4:0] == 5'h1f) begin
              high <= high + 8'h01;
            end
          end
          TCP_M16: {high, low} <= {high, low} + 16'h0001;
          TCP_RELOAD: low <= (low == 8'hff) ? high : low + 8'h01;
          TCP_SPLIT: low <= low + 8'h01;
        endcase
      end
      if (step_high && (mode == TCP_SPLIT)) begin
        high <= high + 8'h01;
      end
    end
  end

endmodule : tcp_byte_pair

// file: logic/tcp_timer_pair.sv
// Two 16-bit timer/counters with an AXI4-Lite register slave and interrupt
// Functional notes
// - Two 16-bit timer or counter registers, independent except when timer zero is in split mode
// - Timer counts once per six-clock machine cycle
// - Counter samples pin per cycle, counts high-to-low
// - Incremented value appears the following machine cycle
// - One falling edge needs two machine cycles
// - Function select bits 6 and 2
// - Mode field bits 5:4 and 1:0
// - Gate bits 7 and 3, nibble per timer
// - Mode register index 89h, resets to zero
// - Gate set: count needs interrupt pin high
// - Function bit picks machine cycle or pin
// - Modes: 13-bit, 16-bit, reload, split
// - Overflow sets flag; ack or software clears
`timescale 1ns/10ps
`include "tcp_defs.svh"

module tcp_timer_pair
  import tcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_input_zero,
  input wire logic event_input_one,
  input wire logic external_interrupt_pin_zero,
  input wire logic external_interrupt_pin_one,
  input wire logic vector_ack_zero,
  input wire logic vector_ack_one,
  output logic irq
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic idx_known(input logic [9:0] idx);
    idx_known = (idx >= `TCP_IDX_RUN) && (idx <= `TCP_IDX_IRQ_EN);
  endfunction : idx_known

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  localparam logic [2:0] MC_LAST = 3'(`TCP_MC_CYCLES - 1);

  tcp_mode_reg_t timer_mode_config;
  logic [1:0] run_control_bit;
  logic [1:0] status;
  logic [1:0] irq_en;
  logic [2:0] mc_div;
  logic mc_tick;
  logic aw_held, w_held;
  logic [9:0] w_idx;
  logic [31:0] w_data, mode_word;
  logic [31:0] load_word [2];
  logic [3:0] w_strb;
  logic do_write;
  logic [1:0] ev_meta, ev_sync, int_meta, int_sync;
  logic [1:0] samp, pend;
  logic [1:0] gate, func;
  tcp_opmode_t om [2];
  logic [1:0] step, step_high, load;
  logic [15:0] cnt [2];
  logic [1:0] ovf_main, ovf_high;
  logic [1:0] flag_set, flag_clr;
  logic [1:0] pin_raw, intp_raw;

  assign pin_raw = {event_input_one, event_input_zero};
  assign intp_raw = {external_interrupt_pin_one, external_interrupt_pin_zero};
  assign gate = {timer_mode_config.one.gate, timer_mode_config.zero.gate};
  assign func = {timer_mode_config.one.func_counter,
                 timer_mode_config.zero.func_counter};
  assign om[0] = timer_mode_config.zero.mode;
  assign om[1] = timer_mode_config.one.mode;
  assign mode_word = merge({24'h0, timer_mode_config}, w_data, w_strb);

  // ********************************************************************
  // Machine cycle divider
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mc_div <= 3'h0;
      mc_tick <= 1'b0;
    end else begin
      mc_div <= (mc_div == MC_LAST) ? 3'h0 : mc_div + 3'h1;
      mc_tick <= (mc_div == MC_LAST);
    end
  end

  // ********************************************************************
  // Per-timer pin sampling, enables and count pairs
  // ********************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    // Pins are asynchronous, so both pass a two-stage synchroniser
    always_ff @(posedge core_clk) begin
      if (rst) begin
        ev_meta[i] <= 1'b0;
        ev_sync[i] <= 1'b0;
        int_meta[i] <= 1'b0;
        int_sync[i] <= 1'b0;
      end else begin
        ev_meta[i] <= pin_raw[i];
        ev_sync[i] <= ev_meta[i];
        int_meta[i] <= intp_raw[i];
        int_sync[i] <= int_meta[i];
      end
    end

    // Edge found on one tick is counted on the next, so an edge costs two cycles
    always_ff @(posedge core_clk) begin
      if (rst) begin
        samp[i] <= 1'b0;
        pend[i] <= 1'b0;
      end else if (mc_tick) begin
        samp[i] <= ev_sync[i];
        pend[i] <= samp[i] && !ev_sync[i];
      end
    end

    always_comb begin
      step[i] = run_control_bit[i] && (!gate[i] || int_sync[i]) && mc_tick
                && (!func[i] || pend[i]);
      if (i == 1 && om[1] == TCP_SPLIT) begin
        step[i] = 1'b0;
      end
    end

    assign load[i] = do_write && (w_idx == ((i == 0) ? `TCP_IDX_CNT0 : `TCP_IDX_CNT1));
    assign load_word[i] = merge({16'h0000, cnt[i]}, w_data, w_strb);

    tcp_byte_pair u_pair (
      .core_clk(core_clk),
      .rst(rst),
      .mode(om[i]),
      .step(step[i]),
      .step_high(step_high[i]),
      .load(load[i]),
      .load_val(load_word[i][15:0]),
      .count(cnt[i]),
      .ovf_main(ovf_main[i]),
      .ovf_high(ovf_high[i])
    );
  end

  // Split high byte of timer zero is a plain timer run by timer one's run bit
  assign step_high[0] = mc_tick && run_control_bit[1];
  assign step_high[1] = 1'b0;

  // ********************************************************************
  // Overflow flags and interrupt
  // ********************************************************************
  assign flag_set[0] = ovf_main[0];
  assign flag_set[1] = (om[0] == TCP_SPLIT) ? ovf_high[0] : ovf_main[1];
  assign flag_clr[0] = vector_ack_zero
                       || (do_write && w_idx == `TCP_IDX_IRQ_CLR && w_strb[0] && w_data[0]);
  assign flag_clr[1] = vector_ack_one
                       || (do_write && w_idx == `TCP_IDX_IRQ_CLR && w_strb[0] && w_data[1]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_en);
    end
  end

  // ********************************************************************
  // Write channel
  // ********************************************************************
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCP_RESP_OKAY;
      w_idx <= 10'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (!aw_held && !s_axi_bvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_held && !s_axi_bvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        w_idx <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_known(w_idx) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Software-written registers
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_mode_config <= `TCP_MODE_RESET;
      run_control_bit <= 2'h0;
      irq_en <= 2'h0;
    end else if (do_write) begin
      if (w_idx == `TCP_IDX_MODE) begin
        timer_mode_config <= mode_word[7:0];
      end
      if (w_idx == `TCP_IDX_RUN && w_strb[0]) begin
        run_control_bit <= {w_data[`TCP_RUN1_BIT], w_data[`TCP_RUN0_BIT]};
      end
      if (w_idx == `TCP_IDX_IRQ_EN && w_strb[0]) begin
        irq_en <= w_data[1:0];
      end
    end
  end

  // ********************************************************************
  // Read channel
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TCP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= idx_known(s_axi_araddr[11:2]) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      unique case (s_axi_araddr[11:2])
        `TCP_IDX_RUN: s_axi_rdata <= {24'h0, status[1], run_control_bit[1],
                                      status[0], run_control_bit[0], 4'h0};
        `TCP_IDX_MODE: s_axi_rdata <= {24'h0, timer_mode_config};
        `TCP_IDX_CNT0: s_axi_rdata <= {16'h0, cnt[0]};
        `TCP_IDX_CNT1: s_axi_rdata <= {16'h0, cnt[1]};
        `TCP_IDX_IRQ_STAT: s_axi_rdata <= {30'h0, status};
        `TCP_IDX_IRQ_EN: s_axi_rdata <= {30'h0, irq_en};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
    mc_tick |=> !mc_tick [*5] ##1 mc_tick)
    else $error("machine cycle tick spacing wrong");
  chk_timer_step: assert property (@(posedge core_clk) disable iff (rst)
    mc_tick && run_control_bit[0] && !gate[0] && !func[0] && om[0] == TCP_M16 && !load[0]
    |=> cnt[0] == $past(cnt[0]) + 16'h0001)
    else $error("timer zero did not count the machine cycle");
  chk_edge_seen: assert property (@(posedge core_clk) disable iff (rst)
    mc_tick && samp[0] && !ev_sync[0] |=> pend[0])
    else $error("falling sample not recorded");
  chk_edge_count: assert property (@(posedge core_clk) disable iff (rst)
    mc_tick && pend[0] && func[0] && run_control_bit[0] && !gate[0]
    && om[0] == TCP_M16 && !load[0] |=> cnt[0] == $past(cnt[0]) + 16'h0001)
    else $error("detected edge not counted");
  chk_edge_rate: assert property (@(posedge core_clk) disable iff (rst)
    mc_tick && pend[0] |=> !pend[0])
    else $error("two counts from one falling edge");
  chk_func_bit: assert property (@(posedge core_clk) disable iff (rst)
    do_write && w_idx == `TCP_IDX_MODE && w_strb[0]
    |=> timer_mode_config[`TCP_FUNC1_BIT] == $past(w_data[6])
        && timer_mode_config[`TCP_FUNC0_BIT] == $past(w_data[2]))
    else $error("function select bit not stored");
  chk_split_stop: assert property (@(posedge core_clk) disable iff (rst)
    om[1] == TCP_SPLIT && !load[1] |=> cnt[1] == $past(cnt[1]))
    else $error("timer one moved while stopped");
  chk_mode_reset: assert property (@(posedge core_clk)
    rst |=> timer_mode_config == `TCP_MODE_RESET)
    else $error("mode register not cleared by reset");
  chk_gate_hold: assert property (@(posedge core_clk) disable iff (rst)
    gate[0] && !int_sync[0] && om[0] == TCP_M16 && !load[0]
    |=> cnt[0] == $past(cnt[0]))
    else $error("gated timer counted with pin low");
  chk_flag_set: assert property (@(posedge core_clk) disable iff (rst)
    flag_set[0] |=> status[0] ##1 (irq == $past(irq_en[0])))
    else $error("overflow flag or interrupt missing");

endmodule : tcp_timer_pair

// file: bench/tcp_pin_src.sv
// Model of the outside circuitry that drives the event and gating pins
`timescale 1ns/10ps

module tcp_pin_src (
  input wire logic core_clk,
  output logic event_input_zero,
  output logic event_input_one,
  output logic external_interrupt_pin_zero,
  output logic external_interrupt_pin_one
);
  // Event pins idle high so the first low level is a real falling edge
  initial begin
    event_input_zero = 1'b1;
    event_input_one = 1'b1;
    external_interrupt_pin_zero = 1'b0;
    external_interrupt_pin_one = 1'b0;
  end

  // Each level is held for hold cycles; callers pass at least one machine cycle
  task automatic falls(input logic sel, input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge core_clk);
      if (sel) event_input_one <= 1'b0;
      else event_input_zero <= 1'b0;
      repeat (hold) @(posedge core_clk);
      if (sel) event_input_one <= 1'b1;
      else event_input_zero <= 1'b1;
    end
  endtask : falls

  task automatic gate_pin(input logic sel, input logic lvl);
    @(posedge core_clk);
    if (sel) external_interrupt_pin_one <= lvl;
    else external_interrupt_pin_zero <= lvl;
  endtask : gate_pin
endmodule : tcp_pin_src

// file: bench/tcp_timer_pair_tb.sv
// Self-checking bench for the timer pair with its register slave
`timescale 1ns/10ps
`include "tcp_defs.svh"

module tcp_timer_pair_tb;
  localparam int MC = `TCP_MC_CYCLES;
  localparam int LIMIT = 20000;
  localparam logic [11:0] A_RUN = {`TCP_IDX_RUN, 2'b00};
  localparam logic [11:0] A_MODE = {`TCP_IDX_MODE, 2'b00};
  localparam logic [11:0] A_CNT0 = {`TCP_IDX_CNT0, 2'b00};
  localparam logic [11:0] A_CNT1 = {`TCP_IDX_CNT1, 2'b00};
  localparam logic [11:0] A_STAT = {`TCP_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_CLR = {`TCP_IDX_IRQ_CLR, 2'b00};
  localparam logic [11:0] A_EN = {`TCP_IDX_IRQ_EN, 2'b00};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, rdat;
  logic ev0, ev1, gp0, gp1;
  logic ack0 = 1'b0, ack1 = 1'b0;
  int bad_count = 0, n_tests = 0, cyc = 0;

  always #5 core_clk = ~core_clk;

  tcp_timer_pair dut_u (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_input_zero(ev0), .event_input_one(ev1),
    .external_interrupt_pin_zero(gp0), .external_interrupt_pin_one(gp1),
    .vector_ack_zero(ack0), .vector_ack_one(ack1), .irq(irq));

  tcp_pin_src pin_u (.core_clk(core_clk), .event_input_zero(ev0), .event_input_one(ev1),
    .external_interrupt_pin_zero(gp0), .external_interrupt_pin_one(gp1));

  // ********************************************************************
  // Bus and compare helpers
  // ********************************************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    last_resp = bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rdat = rdata;
    last_resp = rresp;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_regs;
    rd(A_MODE);
    chk(rdat, 32'h0);
    rd(12'h3fc);
    chk({30'h0, last_resp}, {30'h0, `TCP_RESP_SLVERR});
    wr(12'h3fc, 32'h1);
    chk({30'h0, last_resp}, {30'h0, `TCP_RESP_SLVERR});
    wr(A_MODE, 32'ha5);
    rd(A_MODE);
    chk(rdat, 32'ha5);
    // A second reset in mid-run must bring the mode register back to zero
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(A_MODE);
    chk(rdat, 32'h0);
  endtask : t_regs

  task automatic t_timer;
    wr(A_MODE, 32'h01);
    wr(A_CNT0, 32'h0);
    wr(A_RUN, 32'h10);
    repeat (20 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    rd(A_CNT0);
    rng(rdat, 32'd19, 32'd22);
  endtask : t_timer

  task automatic t_gate;
    wr(A_MODE, 32'h09);
    wr(A_CNT0, 32'h0);
    wr(A_RUN, 32'h10);
    repeat (10 * MC) @(posedge core_clk);
    rd(A_CNT0);
    chk(rdat, 32'h0);
    pin_u.gate_pin(1'b0, 1'b1);
    repeat (10 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    pin_u.gate_pin(1'b0, 1'b0);
    rd(A_CNT0);
    rng(rdat, 32'd8, 32'd12);
  endtask : t_gate

  task automatic t_counter;
    wr(A_MODE, 32'h55);
    wr(A_CNT0, 32'h0);
    wr(A_CNT1, 32'h0);
    wr(A_RUN, 32'h50);
    pin_u.falls(1'b0, 5, MC);
    pin_u.falls(1'b1, 3, MC);
    repeat (4 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    rd(A_CNT0);
    chk(rdat, 32'd5);
    rd(A_CNT1);
    chk(rdat, 32'd3);
  endtask : t_counter

  task automatic t_reload_irq;
    wr(A_MODE, 32'h02);
    wr(A_CNT0, 32'hf0fe);
    wr(A_EN, 32'h1);
    wr(A_RUN, 32'h10);
    repeat (5 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    rd(A_CNT0);
    chk(rdat & 32'hff00, 32'hf000);
    rd(A_STAT);
    chk(rdat, 32'h1);
    rd(A_RUN);
    chk(rdat, 32'h20);
    chk({31'h0, irq}, 32'h1);
    wr(A_EN, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(A_EN, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(A_CLR, 32'h1);
    rd(A_STAT);
    chk(rdat, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Second overflow, cleared this time by the vector acknowledge of timer zero
    wr(A_RUN, 32'h10);
    repeat (20 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    rd(A_STAT);
    chk(rdat, 32'h1);
    @(posedge core_clk);
    ack0 <= 1'b1;
    @(posedge core_clk);
    ack0 <= 1'b0;
    rd(A_STAT);
    chk(rdat, 32'h0);
  endtask : t_reload_irq

  task automatic t_mode0_ack;
    wr(A_MODE, 32'h00);
    wr(A_CNT1, 32'hff1e);
    wr(A_RUN, 32'h40);
    repeat (4 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    rd(A_STAT);
    chk(rdat, 32'h2);
    rd(A_CNT1);
    chk(rdat & 32'hff00, 32'h0);
    @(posedge core_clk);
    ack1 <= 1'b1;
    @(posedge core_clk);
    ack1 <= 1'b0;
    rd(A_STAT);
    chk(rdat, 32'h0);
  endtask : t_mode0_ack

  task automatic t_split;
    wr(A_MODE, 32'h33);
    wr(A_CNT0, 32'h0);
    wr(A_CNT1, 32'h1234);
    wr(A_RUN, 32'h40);
    repeat (10 * MC) @(posedge core_clk);
    wr(A_RUN, 32'h0);
    rd(A_CNT1);
    chk(rdat, 32'h1234);
    rd(A_CNT0);
    chk(rdat & 32'hff, 32'h0);
    rng(rdat >> 8, 32'd8, 32'd12);
  endtask : t_split

  // ********************************************************************
  // Run control
  // ********************************************************************
  task automatic results;
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // Cuts a hang short; the whole run needs under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_timer();
    t_gate();
    t_counter();
    t_reload_irq();
    t_mode0_ack();
    t_split();
    results();
  end
endmodule : tcp_timer_pair_tb
